// ===== core/one_line_mode_port_routing.sv
// one-line routing: validates port setup, captures external converter words,
// routes them and received S/PDIF words to the codec or auxiliary output stream
// assumes configuration ports are static registers on mclk; converter pins on the
// link bit clock; S/PDIF words arrive already on mclk
`timescale 1ns/1ns
`include "olm_defs.svh"
module one_line_mode_port_routing (
  // system clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // external converter link
  input wire logic convBitClk,
  input wire logic convFrameClk,
  input wire logic extConvDataInA,
  input wire logic extConvDataInB,
  // speed fields
  input wire logic [1:0] codecPortSpeedField,
  input wire logic [1:0] auxPortSpeedField,
  // routing and format fields
  input wire logic [1:0] converterOutputRoute,
  input wire logic [2:0] interfaceFormatField,
  input wire logic [1:0] converterOneLineField,
  input wire logic [1:0] playbackOneLineField,
  // miscellaneous control bits
  input wire logic codecPortMasterBit,
  input wire logic auxPortMasterBit,
  input wire logic extConvClockSource,
  // received S/PDIF words
  input wire logic spdifValid,
  input wire logic spdifRight,
  input wire logic [`OLM_SAMPLE_BITS-1:0] spdifSample,
  // codec port output stream
  output logic codecOutValid_q,
  output logic [2:0] codecOutChannel_q,
  output logic [`OLM_SAMPLE_BITS-1:0] codecOutSample_q,
  // auxiliary port output stream
  output logic auxOutValid_q,
  output logic [2:0] auxOutChannel_q,
  output logic [`OLM_SAMPLE_BITS-1:0] auxOutSample_q,
  // status
  output logic configOneOk_q,
  output logic configTwoOk_q,
  output logic captureOn_q,
  output logic convRateOk_q,
  output logic codecBitRatio_q,
  output logic [1:0] codecBitRatioCode_q,
  output logic [1:0] auxBitRatioCode_q,
  output logic [2:0] portFormat_q
);
  // link-side wires
  logic captureEnableLink;
  logic [`OLM_SAMPLE_BITS-1:0] linkWordA;
  logic [`OLM_SAMPLE_BITS-1:0] linkWordB;
  logic linkWordLeft;
  logic [`OLM_CNT_BITS-1:0] linkPhaseLen;
  logic linkToggle;
  logic toggleSync;

  // system-side state
  logic togglePrev_q;
  logic [`OLM_SAMPLE_BITS-1:0] heldA_q;
  logic [`OLM_SAMPLE_BITS-1:0] heldB_q;
  logic heldLeft_q;
  olm_pkg::send_state_t state_q;
  olm_pkg::send_state_t state_d;

  // speed checks
  wire speedsEqual = codecPortSpeedField == auxPortSpeedField;
  wire speedLegal = codecPortSpeedField != 2'h3;
  wire speedSingle = codecPortSpeedField == `OLM_SPEED_SINGLE;
  wire speedQuad = codecPortSpeedField == `OLM_SPEED_QUAD;

  // one-line field checks
  wire convMode1 = converterOneLineField == `OLM_OL_MODE1;
  wire convMode2 = converterOneLineField == `OLM_OL_MODE2;
  wire playMode1 = playbackOneLineField == `OLM_OL_MODE1;
  wire playMode2 = playbackOneLineField == `OLM_OL_MODE2;
  wire fieldsLegal = converterOneLineField != 2'h3 && playbackOneLineField != 2'h3;
  wire mixedModes = (convMode1 && playMode2) || (convMode2 && playMode1);
  wire anyMode1 = convMode1 || playMode1;
  wire anyMode2 = convMode2 || playMode2;
  wire oneLineActive = anyMode1 || anyMode2;
  // mode #2 runs only at single speed, mode #1 not at quad speed
  wire modeSpeedOk = (!anyMode2 || speedSingle) && (!anyMode1 || !speedQuad);

  // shared requirements of both configurations
  wire bothMasters = codecPortMasterBit && auxPortMasterBit;
  wire commonOk = speedsEqual && speedLegal && fieldsLegal && !mixedModes && modeSpeedOk;

  // configuration one: converters on codec port, aux port clocks the converters
  wire cfgOne = commonOk && bothMasters &&
    converterOutputRoute == `OLM_ROUTE_CODEC &&
    extConvClockSource == `OLM_SRC_AUX;

  // configuration two: converters on aux port, codec port clocks the converters
  wire cfgTwo = commonOk && bothMasters &&
    converterOutputRoute == `OLM_ROUTE_AUX &&
    extConvClockSource == `OLM_SRC_CODEC &&
    !playMode2;

  // capture only in a valid one-line setup below quad speed
  wire captureOk = oneLineActive && (cfgOne || cfgTwo) && !speedQuad;

  // codec bit clock ratio by the highest one-line mode in use
  wire [1:0] codecRatio = anyMode2 ? `OLM_RATIO_256FS :
    anyMode1 ? `OLM_RATIO_128FS : `OLM_RATIO_64FS;
  // aux port stays at 64 Fs unless it carries the converter stream in one-line mode #1
  wire [1:0] auxRatio = (cfgTwo && convMode1) ? `OLM_RATIO_128FS : `OLM_RATIO_64FS;

  // the format field only reaches the port outside one-line mode
  wire [2:0] formatSel = oneLineActive ? `OLM_FMT_ONE_LINE : interfaceFormatField;

  // phase length gives the converter bit clock ratio; 128 Fs only at single speed
  wire phase64 = linkPhaseLen == `OLM_PHASE_64FS;
  wire phase128 = linkPhaseLen == `OLM_PHASE_128FS;
  wire rateOk = phase64 || (phase128 && speedSingle);

  // word event from the link domain
  wire wordEvent = toggleSync != togglePrev_q;
  wire acceptWord = wordEvent && captureOn_q && rateOk && state_q == olm_pkg::ST_IDLE;

  // route selection; the converter word format never looks at the format field
  wire convToCodec = configOneOk_q && converterOutputRoute == `OLM_ROUTE_CODEC;
  wire convToAux = configTwoOk_q && converterOutputRoute == `OLM_ROUTE_AUX;
  wire spdifToAux = spdifValid && converterOutputRoute == `OLM_ROUTE_CODEC;

  // channel numbers: line A carries 3/4, line B 5/6
  wire [2:0] chanA = heldLeft_q ? `OLM_CH_A_LEFT : `OLM_CH_A_RIGHT;
  wire [2:0] chanB = heldLeft_q ? `OLM_CH_B_LEFT : `OLM_CH_B_RIGHT;
  wire sendA = state_q == olm_pkg::ST_SEND_A;
  wire sendB = state_q == olm_pkg::ST_SEND_B;
  wire sending = sendA || sendB;
  wire [2:0] convChan = sendA ? chanA : chanB;
  wire [`OLM_SAMPLE_BITS-1:0] convWord = sendA ? heldA_q : heldB_q;

  // next output values
  wire codecValid_d = sending && convToCodec;
  wire [2:0] codecChan_d = codecValid_d ? convChan : 3'h0;
  wire [`OLM_SAMPLE_BITS-1:0] codecSample_d = codecValid_d ? convWord : '0;
  wire auxConv = sending && convToAux;
  wire auxValid_d = auxConv || spdifToAux;
  wire [2:0] auxChan_d = auxConv ? convChan : {2'h0, spdifToAux && spdifRight};
  wire [`OLM_SAMPLE_BITS-1:0] auxSample_d = auxConv ? convWord :
    spdifToAux ? spdifSample : '0;

  // enable crosses into the link domain as a level
  bit_sync #(
    .WIDTH(1)
  ) u_enable_sync (
    .clk(convBitClk),
    .rst_n(rst_n),
    .async(captureOn_q),
    .synced(captureEnableLink)
  );

  // converter deserialiser on the link clock
  ext_conv_rx u_rx (
    .convBitClk(convBitClk),
    .rst_n(rst_n),
    .convFrameClk(convFrameClk),
    .extConvDataInA(extConvDataInA),
    .extConvDataInB(extConvDataInB),
    .captureEnable(captureEnableLink),
    .wordA(linkWordA),
    .wordB(linkWordB),
    .wordLeft(linkWordLeft),
    .phaseLen(linkPhaseLen),
    .wordToggle(linkToggle)
  );

  // word event crosses back as a toggle; data is held a full phase behind it
  bit_sync #(
    .WIDTH(1)
  ) u_toggle_sync (
    .clk(mclk),
    .rst_n(rst_n),
    .async(linkToggle),
    .synced(toggleSync)
  );

  // sender state
  always_comb begin
    state_d = state_q;
    case (state_q)
      olm_pkg::ST_IDLE: begin
        if (acceptWord) begin
          state_d = olm_pkg::ST_SEND_A;
        end
      end
      olm_pkg::ST_SEND_A: begin
        state_d = olm_pkg::ST_SEND_B;
      end
      olm_pkg::ST_SEND_B: begin
        state_d = olm_pkg::ST_IDLE;
      end
      default: begin
        state_d = olm_pkg::ST_IDLE;
      end
    endcase
  end

  // configuration status, registered so outputs come from flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      configOneOk_q <= 1'b0;
      configTwoOk_q <= 1'b0;
      captureOn_q <= 1'b0;
      codecBitRatio_q <= 1'b0;
      codecBitRatioCode_q <= `OLM_RATIO_64FS;
      auxBitRatioCode_q <= `OLM_RATIO_64FS;
      portFormat_q <= 3'h0;
    end else begin
      configOneOk_q <= cfgOne;
      configTwoOk_q <= cfgTwo;
      captureOn_q <= captureOk;
      codecBitRatio_q <= codecRatio != `OLM_RATIO_64FS;
      codecBitRatioCode_q <= codecRatio;
      auxBitRatioCode_q <= auxRatio;
      portFormat_q <= formatSel;
    end
  end

  // word capture and rate status
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      togglePrev_q <= 1'b0;
      heldA_q <= '0;
      heldB_q <= '0;
      heldLeft_q <= 1'b0;
      convRateOk_q <= 1'b0;
      state_q <= olm_pkg::ST_IDLE;
    end else begin
      togglePrev_q <= toggleSync;
      state_q <= state_d;
      if (wordEvent) begin
        convRateOk_q <= rateOk;
      end
      // words at a wrong rate or in a bad setup are dropped
      if (acceptWord) begin
        heldA_q <= linkWordA;
        heldB_q <= linkWordB;
        heldLeft_q <= linkWordLeft;
      end
    end
  end

  // output streams
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      codecOutValid_q <= 1'b0;
      codecOutChannel_q <= 3'h0;
      codecOutSample_q <= '0;
      auxOutValid_q <= 1'b0;
      auxOutChannel_q <= 3'h0;
      auxOutSample_q <= '0;
    end else begin
      codecOutValid_q <= codecValid_d;
      codecOutChannel_q <= codecChan_d;
      codecOutSample_q <= codecSample_d;
      auxOutValid_q <= auxValid_d;
      auxOutChannel_q <= auxChan_d;
      auxOutSample_q <= auxSample_d;
    end
  end
endmodule // one_line_mode_port_routing

// ===== core/olm_defs.svh
// constants for the one-line routing block: field codes, rates, channel numbers
// assumes the includer uses these macros for every code and width it compares
// Summary of operation
// - converter inputs: 24-bit left-justified, 64/128 Fs
// - converter input format ignores port format settings
// - sample converters only in one-line external mode
// - rising-edge sampling, MSB first, left then right
// - 128 Fs single speed only; double is 64
// - no converter inputs at quad speed
// - clock-source bit 1 selects codec port clocks
// - clock-source bit 0 selects auxiliary port clocks
// - configuration one: playback, converters, received S/PDIF
// - configuration one: equal speed fields, equal frames
// - route 00: converters to codec, S/PDIF aux
// - configuration one: both masters, clock-source zero
// - format field applies only outside one-line mode
// - one-line fields 00-10; mixed #1/#2 invalid
// - codec bit clock 64/128/256 Fs by mode
// - configuration two: no S/PDIF, 20-bit 96 kHz
// - route 10: converters on aux, S/PDIF dropped
// - configuration two: source one, masters, playback 00/01
// - six channels per one-line stream, numbered
`ifndef OLM_DEFS_SVH
`define OLM_DEFS_SVH

`define OLM_SAMPLE_BITS 24
`define OLM_CNT_BITS 7
`define OLM_CNT_MAX 7'h7F
`define OLM_LAST_BIT 7'h17
`define OLM_PHASE_64FS 7'h20
`define OLM_PHASE_128FS 7'h40
`define OLM_LEFT_LEVEL 1'b1

`define OLM_SPEED_SINGLE 2'h0
`define OLM_SPEED_DOUBLE 2'h1
`define OLM_SPEED_QUAD 2'h2

`define OLM_ROUTE_CODEC 2'h0
`define OLM_ROUTE_AUX 2'h2

`define OLM_OL_NONE 2'h0
`define OLM_OL_MODE1 2'h1
`define OLM_OL_MODE2 2'h2

`define OLM_SRC_AUX 1'b0
`define OLM_SRC_CODEC 1'b1

`define OLM_RATIO_64FS 2'h0
`define OLM_RATIO_128FS 2'h1
`define OLM_RATIO_256FS 2'h2

`define OLM_FMT_ONE_LINE 3'h7

`define OLM_CH_A_LEFT 3'h3
`define OLM_CH_A_RIGHT 3'h4
`define OLM_CH_B_LEFT 3'h5
`define OLM_CH_B_RIGHT 3'h6

`endif

// ===== core/olm_pkg.sv
// types shared by the one-line routing block
// assumes olm_defs.svh supplies every numeric code
package olm_pkg;
  // gray order along idle, first word, second word
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SEND_A = 2'h1,
    ST_SEND_B = 2'h3
  } send_state_t;
endpackage

// ===== core/bit_sync.sv
// two-flop synchroniser for independent level bits
// assumes each bit is a level or toggle held for several destination clocks
`timescale 1ns/1ns
module bit_sync #(
  parameter int WIDTH = 1
) (
  // destination clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // level crossing
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] meta_q;

  // first stage read only by the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      synced <= '0;
    end else begin
      meta_q <= async;
      synced <= meta_q;
    end
  end
endmodule // bit_sync

// ===== core/ext_conv_rx.sv
// deserialiser for the two external converter lines, on the converter bit clock
// assumes frame clock and data change off the falling edge of the same bit clock
`timescale 1ns/1ns
`include "olm_defs.svh"
module ext_conv_rx (
  // link clock and reset
  input wire logic convBitClk,
  input wire logic rst_n,
  // converter lines, already in this clock's domain
  input wire logic convFrameClk,
  input wire logic extConvDataInA,
  input wire logic extConvDataInB,
  // synchronised enable from the system side
  input wire logic captureEnable,
  // held words and event toggle toward the system side
  output logic [`OLM_SAMPLE_BITS-1:0] wordA,
  output logic [`OLM_SAMPLE_BITS-1:0] wordB,
  output logic wordLeft,
  output logic [`OLM_CNT_BITS-1:0] phaseLen,
  output logic wordToggle
);
  logic frameLast_q;
  logic [`OLM_CNT_BITS-1:0] bitCnt_q;
  logic [`OLM_CNT_BITS-1:0] lastLen_q;
  logic [`OLM_SAMPLE_BITS-1:0] shiftA_q;
  logic [`OLM_SAMPLE_BITS-1:0] shiftB_q;

  wire frameEdge = convFrameClk != frameLast_q;
  wire cntSat = bitCnt_q == `OLM_CNT_MAX;
  wire [`OLM_CNT_BITS-1:0] cntNext = cntSat ? bitCnt_q : bitCnt_q + 1'b1;
  // counter starts saturated: no word until the first frame edge is seen
  wire wordDone = !frameEdge && bitCnt_q == `OLM_LAST_BIT && captureEnable;

  // frame tracking and shifting, MSB first on the rising edge
  always_ff @(posedge convBitClk or negedge rst_n) begin
    if (!rst_n) begin
      frameLast_q <= 1'b0;
      bitCnt_q <= `OLM_CNT_MAX;
      lastLen_q <= '0;
      shiftA_q <= '0;
      shiftB_q <= '0;
    end else begin
      frameLast_q <= convFrameClk;
      if (frameEdge) begin
        bitCnt_q <= 7'h1;
        lastLen_q <= bitCnt_q;
        shiftA_q <= {{(`OLM_SAMPLE_BITS-1){1'b0}}, extConvDataInA};
        shiftB_q <= {{(`OLM_SAMPLE_BITS-1){1'b0}}, extConvDataInB};
      end else begin
        bitCnt_q <= cntNext;
        shiftA_q <= {shiftA_q[`OLM_SAMPLE_BITS-2:0], extConvDataInA};
        shiftB_q <= {shiftB_q[`OLM_SAMPLE_BITS-2:0], extConvDataInB};
      end
    end
  end

  // words held a whole phase so the toggle crossing sees stable data
  always_ff @(posedge convBitClk or negedge rst_n) begin
    if (!rst_n) begin
      wordA <= '0;
      wordB <= '0;
      wordLeft <= 1'b0;
      phaseLen <= '0;
      wordToggle <= 1'b0;
    end else if (wordDone) begin
      wordA <= {shiftA_q[`OLM_SAMPLE_BITS-2:0], extConvDataInA};
      wordB <= {shiftB_q[`OLM_SAMPLE_BITS-2:0], extConvDataInB};
      wordLeft <= convFrameClk == `OLM_LEFT_LEVEL;
      phaseLen <= lastLen_q;
      wordToggle <= ~wordToggle;
    end
  end
endmodule // ext_conv_rx

// ===== tb/olm_routing_properties.sv
// concurrent checks on the one-line routing block's ports
// assumes it is bound onto every instance of one_line_mode_port_routing
`timescale 1ns/1ns
`include "olm_defs.svh"
module olm_routing_checker (
  // system clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // configuration
  input wire logic [1:0] codecPortSpeedField,
  input wire logic [1:0] auxPortSpeedField,
  input wire logic [1:0] converterOutputRoute,
  input wire logic [2:0] interfaceFormatField,
  input wire logic [1:0] converterOneLineField,
  input wire logic [1:0] playbackOneLineField,
  input wire logic codecPortMasterBit,
  input wire logic auxPortMasterBit,
  input wire logic extConvClockSource,
  // received words
  input wire logic spdifValid,
  input wire logic spdifRight,
  input wire logic [`OLM_SAMPLE_BITS-1:0] spdifSample,
  // streams and status
  input wire logic codecOutValid_q,
  input wire logic [2:0] codecOutChannel_q,
  input wire logic auxOutValid_q,
  input wire logic [2:0] auxOutChannel_q,
  input wire logic [`OLM_SAMPLE_BITS-1:0] auxOutSample_q,
  input wire logic configOneOk_q,
  input wire logic configTwoOk_q,
  input wire logic captureOn_q,
  input wire logic [1:0] codecBitRatioCode_q,
  input wire logic [2:0] portFormat_q
);
  logic [1:0] ratioExp_q;
  logic bothMasters;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  assign bothMasters = codecPortMasterBit && auxPortMasterBit;
  // status is registered, so the expectation is registered too
  always_ff @(posedge mclk) begin
    ratioExp_q <= (converterOneLineField == 2'h2 || playbackOneLineField == 2'h2) ? 2'h2 :
      (converterOneLineField == 2'h1 || playbackOneLineField == 2'h1) ? 2'h1 : 2'h0;
  end
  sequence s_wordA(logic v, logic [2:0] ch);
    v && (ch == `OLM_CH_A_LEFT || ch == `OLM_CH_A_RIGHT);
  endsequence
  a_codec_pair_order: assert property (
    s_wordA(codecOutValid_q, codecOutChannel_q) |=>
      codecOutValid_q && codecOutChannel_q == $past(codecOutChannel_q) + 3'h2)
    else $error("codec stream pair out of order");
  a_aux_pair_order: assert property (
    s_wordA(auxOutValid_q, auxOutChannel_q) |=>
      auxOutValid_q && auxOutChannel_q == $past(auxOutChannel_q) + 3'h2)
    else $error("aux stream pair out of order");
  a_invalid_codec_quiet: assert property (
    !configOneOk_q [*8] |=> ##3 !codecOutValid_q)
    else $error("codec stream active without configuration one");
  a_spdif_to_aux: assert property (
    spdifValid && converterOutputRoute == `OLM_ROUTE_CODEC && configOneOk_q |=>
      auxOutValid_q && auxOutChannel_q == {2'h0, $past(spdifRight)} &&
      auxOutSample_q == $past(spdifSample))
    else $error("received word not passed to aux stream");
  a_spdif_dropped: assert property (
    spdifValid && converterOutputRoute == `OLM_ROUTE_AUX |=>
      !(auxOutValid_q && auxOutChannel_q < `OLM_CH_A_LEFT))
    else $error("received word leaked onto aux stream");
  a_format_pass: assert property (
    $past(rst_n) && converterOneLineField == 2'h0 && playbackOneLineField == 2'h0 |=>
      portFormat_q == $past(interfaceFormatField))
    else $error("format field not applied outside one-line mode");
  a_cfg_one_setup: assert property (
    configOneOk_q |-> $past(bothMasters && extConvClockSource == `OLM_SRC_AUX &&
      converterOutputRoute == `OLM_ROUTE_CODEC && codecPortSpeedField == auxPortSpeedField))
    else $error("configuration one accepted with wrong setup");
  a_cfg_two_setup: assert property (
    configTwoOk_q |-> $past(bothMasters && extConvClockSource == `OLM_SRC_CODEC &&
      converterOutputRoute == `OLM_ROUTE_AUX && playbackOneLineField != 2'h2))
    else $error("configuration two accepted with wrong setup");
  a_mode_mix_refused: assert property (
    (converterOneLineField ^ playbackOneLineField) == 2'h3 |=>
      !configOneOk_q && !configTwoOk_q)
    else $error("mixed one-line modes accepted");
  a_codec_ratio: assert property (
    configOneOk_q |-> codecBitRatioCode_q == ratioExp_q)
    else $error("codec bit clock ratio wrong");
  a_quad_no_capture: assert property (
    codecPortSpeedField == `OLM_SPEED_QUAD |=> !captureOn_q)
    else $error("capture on at quad speed");
endmodule // olm_routing_checker
bind one_line_mode_port_routing olm_routing_checker i_chk (.*);

// ===== tb/ext_conv_model.sv
// behavioural pair of external stereo converters sharing one bit clock
// assumes the bench runs bitClk and picks phaseBits legal for the speed
`timescale 1ns/1ns
module ext_conv_model (
  // link clock and control
  input wire logic bitClk,
  input wire logic run,
  input wire logic [6:0] phaseBits,
  // words sent on each line
  input wire logic [23:0] leftA,
  input wire logic [23:0] rightA,
  input wire logic [23:0] leftB,
  input wire logic [23:0] rightB,
  // converter lines
  output logic frameClk,
  output logic dataA,
  output logic dataB
);
  logic [6:0] bitIdx;
  logic [23:0] wa;
  logic [23:0] wb;
  initial begin
    frameClk = 1'b0;
    dataA = 1'b0;
    dataB = 1'b0;
    bitIdx = 7'h00;
  end
  // everything moves on the falling edge so the rising edge sees it settled
  always @(negedge bitClk) begin
    if (!run) begin
      bitIdx = 7'h00;
      dataA = ~dataA;
      dataB = ~dataB;
    end else begin
      if (bitIdx == 7'h00) frameClk = ~frameClk;
      wa = frameClk ? leftA : rightA;
      wb = frameClk ? leftB : rightB;
      if (bitIdx < 7'h18) begin
        dataA = wa[7'h17 - bitIdx];
        dataB = wb[7'h17 - bitIdx];
      end else begin
        // past the lsb the line is not held
        dataA = ~dataA;
        dataB = ~dataB;
      end
      bitIdx = (bitIdx == phaseBits - 7'h01) ? 7'h00 : bitIdx + 7'h01;
    end
  end
endmodule // ext_conv_model

// ===== tb/one_line_mode_port_routing_test.sv
// self-checking bench for the one-line routing block
// assumes the converter model on the link and the bound port checker
`timescale 1ns/1ns
`include "olm_defs.svh"
module one_line_mode_port_routing_test;
  logic mclk = 1'b0;
  logic convBitClk = 1'b0;
  logic rst_n = 1'b0;
  logic run = 1'b0;
  logic [6:0] phaseBits = 7'h40;
  logic convFrameClk, extConvDataInA, extConvDataInB, spdifValid, spdifRight;
  logic [1:0] codecPortSpeedField, auxPortSpeedField, converterOutputRoute;
  logic [1:0] converterOneLineField, playbackOneLineField, codecBitRatioCode_q, auxBitRatioCode_q;
  logic [2:0] interfaceFormatField, codecOutChannel_q, auxOutChannel_q, portFormat_q;
  logic codecPortMasterBit, auxPortMasterBit, extConvClockSource, codecOutValid_q;
  logic auxOutValid_q, configOneOk_q, configTwoOk_q, captureOn_q, convRateOk_q, codecBitRatio_q;
  logic [23:0] spdifSample, codecOutSample_q, auxOutSample_q;
  int fails = 0;
  int cmp_count = 0;
  always #4 mclk = ~mclk;
  // link clock has a 6 ns period against 8 ns for mclk, so its edges drift against mclk
  initial begin
    #1;
    forever #3 convBitClk = ~convBitClk;
  end
  one_line_mode_port_routing i_dut (.*);
  ext_conv_model i_conv (.bitClk(convBitClk), .run(run), .phaseBits(phaseBits),
    .leftA(24'hC3A501), .rightA(24'h5A3C02), .leftB(24'h0F0F03), .rightB(24'h80F004),
    .frameClk(convFrameClk), .dataA(extConvDataInA), .dataB(extConvDataInB));
  task automatic check(string what, logic [23:0] exp, logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask
  // code: cm am auxSpeed(2) route(2) src speed(2) conv(2) play(2)
  task automatic setCfg(logic [12:0] c);
    @(posedge mclk);
    codecPortMasterBit <= c[12];
    auxPortMasterBit <= c[11];
    auxPortSpeedField <= c[10:9];
    converterOutputRoute <= c[8:7];
    extConvClockSource <= c[6];
    codecPortSpeedField <= c[5:4];
    converterOneLineField <= c[3:2];
    playbackOneLineField <= c[1:0];
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic checkPair(logic aux, string what);
    int n;
    logic [2:0] ch;
    n = 0;
    // step past the second word of any pair still standing
    tick();
    while ((aux ? auxOutValid_q : codecOutValid_q) !== 1'b1 && n < 400) begin
      tick();
      n++;
    end
    ch = aux ? auxOutChannel_q : codecOutChannel_q;
    check({what, " valid"}, 24'h1, aux ? auxOutValid_q : codecOutValid_q);
    check({what, " chan A"}, 24'h1, ch == 3'h3 || ch == 3'h4);
    check({what, " word A"}, (ch == 3'h4) ? 24'h5A3C02 : 24'hC3A501,
      aux ? auxOutSample_q : codecOutSample_q);
    tick();
    check({what, " chan B"}, ch + 3'h2, aux ? auxOutChannel_q : codecOutChannel_q);
    check({what, " word B"}, (ch == 3'h4) ? 24'h80F004 : 24'h0F0F03,
      aux ? auxOutSample_q : codecOutSample_q);
  endtask
  task automatic quiet(logic aux, string what);
    int k;
    k = 0;
    repeat (300) begin
      tick();
      if ((aux ? auxOutValid_q : codecOutValid_q) === 1'b1) k++;
    end
    check(what, 24'h0, k[23:0]);
  endtask
  task automatic spdifWord(logic right, logic expOn);
    @(posedge mclk);
    spdifValid <= 1'b1;
    spdifRight <= right;
    spdifSample <= 24'h6B1D2E;
    @(posedge mclk);
    spdifValid <= 1'b0;
    #1;
    check("spdif on aux", expOn, auxOutValid_q && auxOutChannel_q < 3'h3);
    if (expOn) check("spdif chan", right, auxOutChannel_q);
    if (expOn) check("spdif word", 24'h6B1D2E, auxOutSample_q);
  endtask
  task automatic cfgOneSingle();
    setCfg(13'h1804);
    check("cfg one", 24'h1, configOneOk_q);
    check("cfg two", 24'h0, configTwoOk_q);
    check("capture", 24'h1, captureOn_q);
    check("format", `OLM_FMT_ONE_LINE, portFormat_q);
    check("ratio", `OLM_RATIO_128FS, codecBitRatioCode_q);
    check("ratio flag", 24'h1, codecBitRatio_q);
    check("aux ratio", `OLM_RATIO_64FS, auxBitRatioCode_q);
    @(posedge mclk);
    run <= 1'b1;
    checkPair(1'b0, "codec");
    checkPair(1'b0, "codec");
    check("rate ok", 24'h1, convRateOk_q);
    spdifWord(1'b0, 1'b1);
    spdifWord(1'b1, 1'b1);
  endtask
  task automatic doubleRate();
    setCfg(13'h1A14);
    check("cfg one dbl", 24'h1, configOneOk_q);
    quiet(1'b0, "128fs at double");
    check("rate refused", 24'h0, convRateOk_q);
    @(posedge mclk);
    phaseBits <= 7'h20;
    checkPair(1'b0, "codec dbl");
  endtask
  task automatic ratioAndQuad();
    setCfg(13'h1808);
    check("ratio 256", `OLM_RATIO_256FS, codecBitRatioCode_q);
    setCfg(13'h1C20);
    check("cfg one quad", 24'h1, configOneOk_q);
    check("capture quad", 24'h0, captureOn_q);
    check("ratio 64", `OLM_RATIO_64FS, codecBitRatioCode_q);
    check("format plain", interfaceFormatField, portFormat_q);
    quiet(1'b0, "quad stream");
  endtask
  task automatic cfgTwo();
    setCfg(13'h1B55);
    check("cfg two ok", 24'h1, configTwoOk_q);
    check("aux ratio 128", `OLM_RATIO_128FS, auxBitRatioCode_q);
    check("ratio two", `OLM_RATIO_128FS, codecBitRatioCode_q);
    check("cfg one off", 24'h0, configOneOk_q);
    checkPair(1'b1, "aux");
    spdifWord(1'b1, 1'b0);
    quiet(1'b0, "codec in cfg two");
  endtask
  task automatic badCfgs();
    logic [12:0] bad [11] = '{13'h1A18, 13'h1806, 13'h1844, 13'h1884, 13'h1942, 13'h180C,
      13'h1E34, 13'h1A04, 13'h1004, 13'h0804, 13'h1904};
    foreach (bad[i]) begin
      setCfg(bad[i]);
      check("bad cfg one", 24'h0, configOneOk_q);
      check("bad cfg two", 24'h0, configTwoOk_q);
      check("bad capture", 24'h0, captureOn_q);
    end
    quiet(1'b0, "bad cfg stream");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    {codecPortSpeedField, auxPortSpeedField, converterOutputRoute} = 6'h00;
    {converterOneLineField, playbackOneLineField, extConvClockSource} = 5'h00;
    {codecPortMasterBit, auxPortMasterBit} = 2'h3;
    interfaceFormatField = 3'h2;
    {spdifValid, spdifRight, spdifSample} = 26'h0000000;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    cfgOneSingle();
    doubleRate();
    ratioAndQuad();
    cfgTwo();
    badCfgs();
    tally_and_finish();
  end
  initial begin
    #200000;
    fails++;
    $display("BAD watchdog expected done seen hang");
    tally_and_finish();
  end
endmodule // one_line_mode_port_routing_test
